// File: rtl/iox_pkg.sv
/*
 * iox_pkg: constants and types shared by the external bus sequencer.
 * Assumes a single 50 MHz system clock.
 */
package iox_pkg;
    localparam int          CLK_MHZ         = 50;
    localparam int          NUM_IRQ         = 5;
    localparam logic [3:0]  WS_MIN          = 4'h1;
    localparam logic [3:0]  WS_MAX          = 4'hE;
    localparam logic [3:0]  WS_RESET        = 4'h1;
    localparam int          XCH_MIN_CYCLES  = 3;
    localparam logic [7:0]  BUS_TIMEOUT     = 8'hFF;
    localparam int          DMA_LIMIT_NS    = 20480;
    localparam int          DMA_LIMIT_CYC   = DMA_LIMIT_NS * CLK_MHZ / 1000;
    localparam logic [4:0]  IRQ_POL_RESET   = 5'h00;
    localparam logic [4:0]  IRQ_EDGE_RESET  = 5'h00;

    typedef enum logic [1:0] {
        IOX_REG_MEM,
        IOX_REG_IO,
        IOX_REG_XCH
    } iox_region_t;

    typedef enum {
        IOX_IDLE,
        IOX_ADDR_WS,
        IOX_DATA_WS,
        IOX_READY,
        IOX_DONE
    } iox_state_t;

    function automatic logic [3:0] iox_clamp_ws(input logic [3:0] ws);
        if (ws < WS_MIN)
            return WS_MIN;
        else if (ws > WS_MAX)
            return WS_MAX;
        return ws;
    endfunction : iox_clamp_ws
endpackage : iox_pkg

// File: rtl/iox_irq_if.sv
/*
 * iox_irq_if: carries interrupt configuration and events between the
 * bus sequencer and its interrupt front end.
 */
`timescale 1ns/1ps
interface iox_irq_if;
    logic [4:0] pol_high;
    logic [4:0] edge_mode;
    logic [4:0] irq_sync;
    logic [4:0] irq_event;
    modport front (input pol_high, input edge_mode, input irq_sync, output irq_event);
    modport ctrl  (output pol_high, output edge_mode, output irq_sync, input irq_event);
endinterface : iox_irq_if

// File: rtl/iox_irq_front.sv
/*
 * iox_irq_front: polarity and edge/level detection of external requests.
 * Assumes inputs already synchronised to SYS_CLK_I.
 */
`timescale 1ns/1ps
module iox_irq_front (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    iox_irq_if.front  irq
);
    logic [4:0] active;
    logic [4:0] prev;
    logic [4:0] next_prev;
    logic [4:0] ev;

    always_comb begin
        active    = irq.irq_sync ^ ~irq.pol_high;
        next_prev = active;
        ev        = active & (~irq.edge_mode | ~prev);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            prev <= 5'h00;
        else
            prev <= next_prev;
    end

    assign irq.irq_event = ev;

    AST_EDGE_ONCE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (irq.edge_mode[0] && $stable(irq.edge_mode) && prev[0]) |-> !irq.irq_event[0])
        else $error("edge mode event repeated while held");
endmodule : iox_irq_front

// File: rtl/iox_bus_ctrl.sv
/*
 * iox_bus_ctrl: external bus sequencing for I/O, exchange memory and DMA
 * slave accesses, plus external interrupt handling.
 * Assumes a processor-side request strobe with region decode done outside,
 * and pin inputs asynchronous to SYS_CLK_I.
 */
// Functional notes
// - I/O wait states programmable from one to fourteen before ready sampled.
// - bus time-out ends accesses with ready stuck deasserted.
// - I/O region always inserts at least one wait state.
// - separate I/O and memory buffer enables; memory enable serves every non-I/O region.
// - five external interrupt inputs forwarded to the processor.
// - interrupts default active low, each programmable active high.
// - programmable acknowledge output clears serviced held requests.
// - optional edge detection gives one event per held request.
// - controller can generate data parity for I/O accesses.
// - exchange writes withhold strobes until busy indication clears.
// - exchange access starts with address wait states sampling busy.
// - ready deasserted in exchange area means memory busy.
// - ready asserted at second cycle proceeds to data wait states.
// - busy during address phase stalls, then data wait states follow.
// - exchange accesses last at least three clock cycles.
// - exchange is 32-bit true dual port, no arbitration here.
// - DMA request held too long flags an error.
// - DMA bus time-out aborts cycle and interrupts the processor.
// - bus time-out of processor and DMA accesses alike asserts memory exception.
`timescale 1ns/1ps
module iox_bus_ctrl (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        ACC_REQ_I,
    input  wire logic [1:0]  ACC_REGION_I,
    input  wire logic        ACC_WRITE_I,
    input  wire logic [31:0] ACC_WDATA_I,
    input  wire logic        ACC_DMA_I,
    input  wire logic [3:0]  IO_WS_I,
    input  wire logic [3:0]  DATA_WS_I,
    input  wire logic        IO_PARITY_GEN_I,
    input  wire logic        BUS_READY_N_I,
    input  wire logic        DMA_REQUEST_N_I,
    input  wire logic [4:0]  EXT_IRQ_I,
    input  wire logic [4:0]  IRQ_POL_HIGH_I,
    input  wire logic [4:0]  IRQ_EDGE_I,
    input  wire logic        IRQ_ACK_EN_I,
    input  wire logic [4:0]  IRQ_CLEAR_I,
    output logic             ACC_DONE_O,
    output logic             ACC_TIMEOUT_O,
    output logic             WRITE_STROBE_O,
    output logic             IO_BUFFER_EN_O,
    output logic             MEM_BUFFER_EN_O,
    output logic             DATA_PARITY_O,
    output logic             MEM_EXCEPTION_N_O,
    output logic [4:0]       IRQ_PENDING_O,
    output logic             EXT_IRQ_ACK_OUT_O,
    output logic             DMA_TIMEOUT_IRQ_O,
    output logic             DMA_ERROR_O
);
    iox_pkg::iox_state_t state, next_state;
    logic [3:0]  ws_cnt, next_ws_cnt;
    logic [7:0]  to_cnt, next_to_cnt;
    logic [1:0]  cyc_cnt, next_cyc_cnt;
    logic [15:0] dma_cnt, next_dma_cnt;
    logic [1:0]  region, next_region;
    logic        is_write, next_is_write;
    logic        is_dma, next_is_dma;
    logic        done, next_done;
    logic        tmo, next_tmo;
    logic        wstb, next_wstb;
    logic        io_buffer_en, next_io_buffer_en;
    logic        mem_buffer_en, next_mem_buffer_en;
    logic        par, next_par;
    logic        mem_exception_n_n, next_mem_exception_n_n;
    logic        dma_irq, next_dma_irq;
    logic        dma_err, next_dma_err;
    logic [4:0]  pend, next_pend;
    logic        ack, next_ack;
    logic [1:0]  rdy_s, dreq_s;
    logic [4:0]  irq_s1, irq_s2;
    logic        ready;
    logic        to_hit;

    iox_irq_if irq_bus();

    // two-flop synchronisers; irq flops reset to the inactive level of their polarity
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rdy_s  <= 2'h3;
            dreq_s <= 2'h3;
            irq_s1 <= ~IRQ_POL_HIGH_I;
            irq_s2 <= ~IRQ_POL_HIGH_I;
        end else begin
            rdy_s  <= {rdy_s[0], BUS_READY_N_I};
            dreq_s <= {dreq_s[0], DMA_REQUEST_N_I};
            irq_s1 <= EXT_IRQ_I;
            irq_s2 <= irq_s1;
        end
    end

    assign ready            = !rdy_s[1];
    assign irq_bus.irq_sync  = irq_s2;
    assign irq_bus.pol_high  = IRQ_POL_HIGH_I;
    assign irq_bus.edge_mode = IRQ_EDGE_I;

    iox_irq_front u_front (
        .sys_clk_i (SYS_CLK_I),
        .rst_i     (RST_I),
        .irq       (irq_bus.front)
    );

    assign to_hit = (to_cnt == iox_pkg::BUS_TIMEOUT) && !ready;

    always_comb begin
        next_state    = state;
        next_ws_cnt   = ws_cnt;
        next_to_cnt   = to_cnt;
        next_cyc_cnt  = cyc_cnt;
        next_region   = region;
        next_is_write = is_write;
        next_is_dma   = is_dma;
        next_done     = 1'b0;
        next_tmo      = 1'b0;
        next_wstb     = 1'b0;
        next_io_buffer_en    = io_buffer_en;
        next_mem_buffer_en   = mem_buffer_en;
        next_par      = par;
        next_mem_exception_n_n   = 1'b1;
        next_dma_irq  = 1'b0;
        if (state != iox_pkg::IOX_IDLE && cyc_cnt != 2'h3)
            next_cyc_cnt = cyc_cnt + 2'h1;
        if (state != iox_pkg::IOX_IDLE && to_cnt != iox_pkg::BUS_TIMEOUT)
            next_to_cnt = to_cnt + 8'h01;
        unique case (state)
            iox_pkg::IOX_IDLE: begin
                if (ACC_REQ_I) begin
                    next_region   = ACC_REGION_I;
                    next_is_write = ACC_WRITE_I;
                    next_is_dma   = ACC_DMA_I;
                    next_to_cnt   = 8'h00;
                    next_cyc_cnt  = 2'h1;
                    next_io_buffer_en    = (ACC_REGION_I == 2'(iox_pkg::IOX_REG_IO));
                    next_mem_buffer_en   = !next_io_buffer_en;
                    next_par      = IO_PARITY_GEN_I & ^ACC_WDATA_I;
                    if (ACC_REGION_I == 2'(iox_pkg::IOX_REG_IO)) begin
                        next_ws_cnt = iox_pkg::iox_clamp_ws(IO_WS_I);
                        next_state  = iox_pkg::IOX_DATA_WS;
                    end else if (ACC_REGION_I == 2'(iox_pkg::IOX_REG_XCH)) begin
                        next_state  = iox_pkg::IOX_ADDR_WS;
                    end else begin
                        next_ws_cnt = DATA_WS_I;
                        next_state  = iox_pkg::IOX_DATA_WS;
                    end
                end
            end
            iox_pkg::IOX_ADDR_WS: begin
                if (to_hit)
                    next_state = iox_pkg::IOX_DONE;
                else if (ready) begin
                    next_ws_cnt = DATA_WS_I;
                    next_state  = iox_pkg::IOX_DATA_WS;
                end
            end
            iox_pkg::IOX_DATA_WS: begin
                if (ws_cnt > 4'h1)
                    next_ws_cnt = ws_cnt - 4'h1;
                else if (region == 2'(iox_pkg::IOX_REG_MEM))
                    next_state = iox_pkg::IOX_DONE;
                else
                    next_state = iox_pkg::IOX_READY;
            end
            iox_pkg::IOX_READY: begin
                if (to_hit) begin
                    next_state = iox_pkg::IOX_DONE;
                end else if ((ready || region == 2'(iox_pkg::IOX_REG_XCH))
                             && (cyc_cnt >= 2'(iox_pkg::XCH_MIN_CYCLES - 1))) begin
                    next_wstb  = is_write;
                    next_state = iox_pkg::IOX_DONE;
                end
            end
            iox_pkg::IOX_DONE: begin
                next_done   = 1'b1;
                next_io_buffer_en  = 1'b0;
                next_mem_buffer_en = 1'b0;
                if (to_cnt == iox_pkg::BUS_TIMEOUT) begin
                    next_tmo     = 1'b1;
                    next_mem_exception_n_n  = 1'b0;
                    next_dma_irq = is_dma;
                end
                next_state = iox_pkg::IOX_IDLE;
            end
        endcase
    end

    always_comb begin
        next_dma_cnt = 16'h0000;
        next_dma_err = dma_err;
        if (!dreq_s[1]) begin
            if (dma_cnt == 16'(iox_pkg::DMA_LIMIT_CYC))
                next_dma_err = 1'b1;
            else
                next_dma_cnt = dma_cnt + 16'h0001;
            if (dma_cnt == 16'(iox_pkg::DMA_LIMIT_CYC))
                next_dma_cnt = dma_cnt;
        end
    end

    always_comb begin
        next_pend = (pend & ~IRQ_CLEAR_I) | irq_bus.irq_event;
        next_ack  = IRQ_ACK_EN_I && (IRQ_CLEAR_I & pend) != 5'h00;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state    <= iox_pkg::IOX_IDLE;
            ws_cnt   <= iox_pkg::WS_RESET;
            to_cnt   <= 8'h00;
            cyc_cnt  <= 2'h0;
            dma_cnt  <= 16'h0000;
            region   <= 2'h0;
            is_write <= 1'b0;
            is_dma   <= 1'b0;
            done     <= 1'b0;
            tmo      <= 1'b0;
            wstb     <= 1'b0;
            io_buffer_en    <= 1'b0;
            mem_buffer_en   <= 1'b0;
            par      <= 1'b0;
            mem_exception_n_n   <= 1'b1;
            dma_irq  <= 1'b0;
            dma_err  <= 1'b0;
            pend     <= 5'h00;
            ack      <= 1'b0;
        end else begin
            state    <= next_state;
            ws_cnt   <= next_ws_cnt;
            to_cnt   <= next_to_cnt;
            cyc_cnt  <= next_cyc_cnt;
            dma_cnt  <= next_dma_cnt;
            region   <= next_region;
            is_write <= next_is_write;
            is_dma   <= next_is_dma;
            done     <= next_done;
            tmo      <= next_tmo;
            wstb     <= next_wstb;
            io_buffer_en    <= next_io_buffer_en;
            mem_buffer_en   <= next_mem_buffer_en;
            par      <= next_par;
            mem_exception_n_n   <= next_mem_exception_n_n;
            dma_irq  <= next_dma_irq;
            dma_err  <= next_dma_err;
            pend     <= next_pend;
            ack      <= next_ack;
        end
    end

    assign ACC_DONE_O        = done;
    assign ACC_TIMEOUT_O     = tmo;
    assign WRITE_STROBE_O    = wstb;
    assign IO_BUFFER_EN_O    = io_buffer_en;
    assign MEM_BUFFER_EN_O   = mem_buffer_en;
    assign DATA_PARITY_O     = par;
    assign MEM_EXCEPTION_N_O = mem_exception_n_n;
    assign IRQ_PENDING_O     = pend;
    assign EXT_IRQ_ACK_OUT_O = ack;
    assign DMA_TIMEOUT_IRQ_O = dma_irq;
    assign DMA_ERROR_O       = dma_err;

    sequence s_io_start;
        state == iox_pkg::IOX_IDLE && ACC_REQ_I && ACC_REGION_I == 2'(iox_pkg::IOX_REG_IO);
    endsequence

    sequence s_take;
        state == iox_pkg::IOX_IDLE && ACC_REQ_I;
    endsequence

    sequence s_xch_busy;
        state == iox_pkg::IOX_ADDR_WS && !to_hit && !ready;
    endsequence

    sequence s_xch_free;
        state == iox_pkg::IOX_ADDR_WS && !to_hit && ready;
    endsequence

    AST_IO_MIN_WS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_io_start |=> !done [*2])
        else $error("I/O access finished without wait state");
    AST_IO_WS_RANGE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_DATA_WS && region == 2'(iox_pkg::IOX_REG_IO) |-> ws_cnt >= 4'h1 && ws_cnt <= 4'hE)
        else $error("I/O wait count out of range");
    AST_IO_STALL: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_READY && !ready && !to_hit |=> state == iox_pkg::IOX_READY)
        else $error("access left ready wait while not ready");
    AST_TIMEOUT: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_READY && to_hit |=> ##1 tmo && !mem_exception_n_n)
        else $error("time-out not reported");
    AST_BUF_EXCL: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !(io_buffer_en && mem_buffer_en))
        else $error("both buffer enables active");
    AST_XCH_BUSY: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_ADDR_WS && !ready |=> !wstb)
        else $error("write strobe while exchange busy");
    AST_XCH_MIN: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_IDLE && ACC_REQ_I && ACC_REGION_I == 2'(iox_pkg::IOX_REG_XCH)
        |=> !done [*3])
        else $error("exchange access shorter than three cycles");
    AST_DMA_IRQ: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        tmo && is_dma |-> dma_irq)
        else $error("DMA time-out without interrupt");
    AST_DMA_ERR: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(dma_err) |-> $past(dma_cnt) == 16'(iox_pkg::DMA_LIMIT_CYC))
        else $error("DMA error at wrong count");
    AST_PEND_SET: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        irq_bus.irq_event[0] |=> pend[0])
        else $error("interrupt event lost");
    AST_TO_RESTART: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_take |=> to_cnt == 8'h00 && cyc_cnt == 2'h1)
        else $error("time-out counter not restarted");
    AST_XCH_STALL: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_xch_busy |=> state == iox_pkg::IOX_ADDR_WS && !wstb)
        else $error("exchange access left busy wait");
    AST_XCH_GO: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_xch_free |=> state == iox_pkg::IOX_DATA_WS && ws_cnt == $past(DATA_WS_I))
        else $error("exchange access did not start data wait states");
    AST_IO_READY_DONE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        state == iox_pkg::IOX_READY && region == 2'(iox_pkg::IOX_REG_IO) && ready && !to_hit
        |=> state == iox_pkg::IOX_DONE)
        else $error("I/O access not ended on ready");
    AST_MEM_EXCEPTION_N_TMO: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !mem_exception_n_n |-> tmo && done)
        else $error("memory exception without time-out");
    AST_STRB_DONE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wstb |-> is_write ##1 done)
        else $error("write strobe not followed by done");
    AST_BUF_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        done |-> !io_buffer_en && !mem_buffer_en)
        else $error("buffer enable held after access");
    AST_ACK_ENABLED: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        ack |-> $past(IRQ_ACK_EN_I))
        else $error("acknowledge while not enabled");
    AST_DMA_ERR_STICKY: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        dma_err |=> dma_err)
        else $error("DMA error flag dropped");
endmodule : iox_bus_ctrl

// File: rtl/unused_placeholder_none.sv
/*
 * intentionally empty companion; no logic.
 */

// File: tb/iox_far_model.sv
/*
 * iox_far_model: far-side I/O unit or dual-port memory, plus one
 * interrupting unit whose request line is held high until acknowledged.
 * Assumes sel_i is high from the request until the access completes.
 */
`timescale 1ns/1ps
module iox_far_model (
    input  wire logic clk_i,
    input  wire logic sel_i,
    input  wire logic stuck_i,
    input  int        hold_i,
    input  wire logic raise_i,
    input  wire logic ack_i,
    output logic      bus_ready_n_o,
    output logic      coproc_attention_irq_o
);
    int cnt = 0;

    initial coproc_attention_irq_o = 1'b0;

    always @(posedge clk_i) begin
        cnt <= sel_i ? cnt + 1 : 0;
        if (ack_i === 1'b1)
            coproc_attention_irq_o <= 1'b0;
        else if (raise_i)
            coproc_attention_irq_o <= 1'b1;
    end

    // pulled up when idle; asserted at once unless slow, busy or stuck
    assign bus_ready_n_o = !sel_i | stuck_i | (cnt < hold_i);
endmodule : iox_far_model

// File: tb/iox_bus_ctrl_test.sv
/*
 * iox_bus_ctrl_test: self-checking bench for the external bus sequencer.
 * Assumes iox_pkg, the interrupt interface and front end, and the far-side
 * model are compiled before this file.
 */
`timescale 1ns/1ps
module iox_bus_ctrl_test;
    logic        clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, dma = 1'b0, pgen = 1'b0;
    logic        dreq_n = 1'b1, ack_en = 1'b0, sel = 1'b0, stk = 1'b0, raise = 1'b0;
    logic [1:0]  rg = 2'h0;
    logic [3:0]  ws = 4'h1, dws = 4'h1;
    logic [31:0] wd = 32'h0, seed = 32'h43;
    logic [4:0]  pins = 5'h1E, pol = 5'h01, edg = 5'h01, clr = 5'h00, pend;
    logic        rdy_n, coproc_attention_irq, done, tmo, strb, io_buffer_en, mem_buffer_en, par, mem_exception_n_n, ack_out, dirq, derr;
    logic        io_seen, mem_seen, t_to, t_mx, t_dirq, t_par, t_ack;
    int          hold = 0, failures = 0, cmp_count = 0, lat, n_strb, first_strb, base;
    logic [3:0]  io_ws [5] = '{4'h0, 4'h1, 4'h7, 4'hE, 4'hF};

    always #10 clk = ~clk;

    iox_bus_ctrl uut (
        .SYS_CLK_I(clk), .RST_I(rst), .ACC_REQ_I(req), .ACC_REGION_I(rg), .ACC_WRITE_I(wr),
        .ACC_WDATA_I(wd), .ACC_DMA_I(dma), .IO_WS_I(ws), .DATA_WS_I(dws), .IO_PARITY_GEN_I(pgen),
        .BUS_READY_N_I(rdy_n), .DMA_REQUEST_N_I(dreq_n), .EXT_IRQ_I({pins[4:1], coproc_attention_irq}),
        .IRQ_POL_HIGH_I(pol), .IRQ_EDGE_I(edg), .IRQ_ACK_EN_I(ack_en), .IRQ_CLEAR_I(clr),
        .ACC_DONE_O(done), .ACC_TIMEOUT_O(tmo), .WRITE_STROBE_O(strb), .IO_BUFFER_EN_O(io_buffer_en),
        .MEM_BUFFER_EN_O(mem_buffer_en), .DATA_PARITY_O(par), .MEM_EXCEPTION_N_O(mem_exception_n_n),
        .IRQ_PENDING_O(pend), .EXT_IRQ_ACK_OUT_O(ack_out), .DMA_TIMEOUT_IRQ_O(dirq), .DMA_ERROR_O(derr)
    );

    iox_far_model far (
        .clk_i(clk), .sel_i(sel), .stuck_i(stk), .hold_i(hold), .raise_i(raise), .ack_i(ack_out),
        .bus_ready_n_o(rdy_n), .coproc_attention_irq_o(coproc_attention_irq)
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // reference latency: edges from the taking edge to the done cycle
    function automatic int exp_lat(input logic [1:0] r, input logic [3:0] s, input logic [3:0] d);
        int w;
        w = (r == 2'h1) ? int'(s) : int'(d);
        if (w < 1) w = 1;
        if (r == 2'h1 && w > 14) w = 14;
        return (r == 2'h1) ? w + 3 : w + 2;
    endfunction : exp_lat

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic acc(input logic [1:0] r, input logic w, input logic [3:0] s, input logic d, input int h,
                       input logic k);
        @(negedge clk);
        {rg, wr, ws, dma, hold, stk} = {r, w, s, d, h, k};
        wd = xs();
        req = 1'b1;
        sel = 1'b1;
        {io_seen, mem_seen, t_to, t_mx, t_dirq} = 5'h00;
        {n_strb, first_strb, lat} = {32'd0, 32'd0, 32'd0};
        do begin
            @(negedge clk);
            req = 1'b0;
            lat++;
            io_seen |= io_buffer_en;
            mem_seen |= mem_buffer_en;
            t_to |= tmo;
            t_mx |= !mem_exception_n_n;
            t_dirq |= dirq;
            if (strb === 1'b1) begin
                n_strb++;
                if (first_strb == 0) first_strb = lat;
            end
        end while (done !== 1'b1 && lat < 400);
        chk(done === 1'b1, "access never finished");
        t_par = par;
        {sel, stk, hold} = {1'b0, 1'b0, 32'd0};
    endtask : acc

    task automatic wait_pend(input int b, input logic v);
        int n;
        n = 0;
        while (pend[b] !== v && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(pend[b] === v, "pending bit");
    endtask : wait_pend

    task automatic clear_irq(input int b);
        @(negedge clk);
        clr[b] = 1'b1;
        @(negedge clk);
        clr[b] = 1'b0;
        t_ack = ack_out;
        @(negedge clk);
        t_ack |= ack_out;
    endtask : clear_irq

    initial begin
        #400000;
        failures++;
        give_verdict();
    end

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        foreach (io_ws[i]) begin
            acc(2'h1, 1'b0, io_ws[i], 1'b0, 0, 1'b0);
            chk(lat == exp_lat(2'h1, io_ws[i], dws), "io wait states");
            chk(io_seen && !mem_seen && n_strb == 0, "io buffer enable");
        end
        for (int d = 0; d < 4; d++) begin
            dws = d[3:0];
            acc(2'h0, 1'b0, 4'(xs()), 1'b0, 0, 1'b0);
            chk(lat == exp_lat(2'h0, ws, dws) && mem_seen && !io_seen, "memory access");
        end
        pgen = 1'b1;
        acc(2'h1, 1'b1, 4'h2, 1'b0, 0, 1'b0);
        chk(t_par === ^wd && n_strb == 1, "io write parity");
        acc(2'h1, 1'b0, 4'h1, 1'b0, 0, 1'b0);
        base = lat;
        acc(2'h1, 1'b0, 4'h1, 1'b0, 10, 1'b0);
        chk(lat - base >= 7 && lat - base <= 10, "slow io stretch");
        dws = 4'h1;
        acc(2'h2, 1'b1, 4'h1, 1'b0, 0, 1'b0);
        base = lat;
        chk(lat >= iox_pkg::XCH_MIN_CYCLES && n_strb == 1, "exchange minimum");
        dws = 4'h3;
        acc(2'h2, 1'b1, 4'h1, 1'b0, 0, 1'b0);
        chk(lat - base == 2, "exchange data wait states");
        dws = 4'h1;
        acc(2'h2, 1'b1, 4'h1, 1'b0, 12, 1'b0);
        chk(lat >= base + 9 && n_strb == 1, "exchange busy stall");
        chk(first_strb > 12, "strobe while busy");
        acc(2'h1, 1'b0, 4'h1, 1'b0, 0, 1'b1);
        chk(t_to && t_mx && !t_dirq && lat >= 255 && lat <= 260, "cpu time-out");
        acc(2'h1, 1'b0, 4'h1, 1'b1, 0, 1'b1);
        chk(t_to && t_dirq && t_mx, "dma time-out");
        acc(2'h1, 1'b0, 4'h1, 1'b0, 0, 1'b0);
        chk(lat == exp_lat(2'h1, 4'h1, dws) && !t_to, "access after time-out");
        dreq_n = 1'b0;
        repeat (500) @(negedge clk);
        dreq_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(derr === 1'b0, "short dma request");
        dreq_n = 1'b0;
        repeat (1100) @(negedge clk);
        dreq_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(derr === 1'b1, "long dma request");
        for (int b = 1; b < 5; b++) begin
            pins[b] = 1'b0;
            wait_pend(b, 1'b1);
            clear_irq(b);
            wait_pend(b, 1'b1);
            pins[b] = 1'b1;
            repeat (4) @(negedge clk);
            clear_irq(b);
            wait_pend(b, 1'b0);
        end
        ack_en = 1'b1;
        raise = 1'b1;
        @(negedge clk);
        raise = 1'b0;
        wait_pend(0, 1'b1);
        clear_irq(0);
        chk(t_ack === 1'b1, "acknowledge pulse");
        repeat (4) @(negedge clk);
        chk(coproc_attention_irq === 1'b0 && pend[0] === 1'b0, "request withdrawn");
        ack_en = 1'b0;
        raise = 1'b1;
        @(negedge clk);
        raise = 1'b0;
        wait_pend(0, 1'b1);
        clear_irq(0);
        repeat (6) @(negedge clk);
        chk(t_ack === 1'b0 && coproc_attention_irq === 1'b1 && pend[0] === 1'b0, "held edge request");
        chk(derr === 1'b1, "dma error sticky");
        give_verdict();
    end
endmodule : iox_bus_ctrl_test
